/* File: src/vlid_pkg.sv */
// shared constants and types of the variable-length instruction decoder
package vlid_pkg;
  localparam int HW_W = 16;
  localparam int WORD_W = 32;
  localparam int MAJ_W = 6;
  localparam int REG5_W = 5;
  localparam int REG3_W = 3;
  localparam int REG3_FIELDS = 3;
  // major opcode bit positions
  localparam int MAJ32_LSB = 26;
  localparam int MAJ16_LSB = 10;
  // 5-bit register fields of 32-bit encodings, in order of use
  localparam int R32_A_LSB = 21;
  localparam int R32_B_LSB = 16;
  localparam int R32_C_LSB = 11;
  localparam int R32_D_LSB = 6;
  // 3-bit register fields of 16-bit encodings
  localparam int R3_A_LSB = 7;
  localparam int R3_B_LSB = 4;
  localparam int R3_C_LSB = 1;
  // 5-bit register fields of 16-bit encodings
  localparam int R5_HI_LSB = 5;
  localparam int R5_LO_LSB = 0;
  // minor opcode of 12-bit immediate formats
  localparam int MINOR12_LSB = 12;
  // offset shifts: halfword targets in variable mode, word targets in fixed mode
  localparam int SHIFT_VAR = 1;
  localparam int SHIFT_FIXED = 2;
  // one bit per major opcode value
  localparam logic [63:0] MAJOR_IS16_MAP = 64'hEEEEEEEEEEEEEEEE;
  localparam logic [63:0] MAJOR_MINOR12_MAP = 64'h0000000000000100;
  localparam logic [63:0] MAJOR_IMM_RIGHT_MAP = 64'hFFFFFFFFFFFFFEFF;
  // 3-bit specifier to register number, entry i at bits 5*i+4..5*i
  localparam logic [39:0] REG3_MAP = {5'h11, 5'h10, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02};
  localparam logic [HW_W-1:0] HW_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_RESET = 32'h00000000;

  typedef struct packed {
    logic is32;
    logic [MAJ_W-1:0] major;
    logic imm_right;
    logic minor12_sel;
    logic [REG5_W-1:0] reg_a;
    logic [REG5_W-1:0] reg_b;
    logic [REG5_W-1:0] reg_c;
    logic [REG5_W-1:0] reg_d;
    logic [REG5_W-1:0] reg3_a;
    logic [REG5_W-1:0] reg3_b;
    logic [REG5_W-1:0] reg3_c;
    logic [REG5_W-1:0] reg5_hi;
    logic [REG5_W-1:0] reg5_lo;
    logic [25:0] imm26;
    logic [15:0] imm16;
    logic [11:0] imm12;
    logic [3:0] minor12;
    logic [5:0] minor6;
    logic [9:0] imm10;
    logic [6:0] imm7;
    logic [3:0] imm4;
    logic [WORD_W-1:0] br_off16;
    logic [WORD_W-1:0] jmp_off26;
    logic [WORD_W-1:0] br_off10;
    logic [WORD_W-1:0] br_off7;
    logic [WORD_W-1:0] raw;
  } fields_t;

  typedef struct packed {
    logic [1:0] rst_sync;
  } rst_t;

  typedef struct packed {
    logic word_valid;
    logic [WORD_W-1:0] word;
    logic idx;
    logic start_half;
    logic hold_valid;
    logic [HW_W-1:0] hold_hw;
    logic out_valid;
    fields_t out;
  } dec_state_t;
endpackage

/* File: src/reg3_map.sv */
// maps the three 3-bit register specifiers of a 16-bit encoding to register numbers
`timescale 1ns/10ps
module reg3_map
  import vlid_pkg::*;
(
  input wire logic [HW_W-1:0] hw,
  output logic [REG3_FIELDS*REG5_W-1:0] reg_num
);
  localparam int R3_LSB [REG3_FIELDS] = '{R3_A_LSB, R3_B_LSB, R3_C_LSB};

  genvar g;
  generate
    for (g = 0; g < REG3_FIELDS; g++) begin : g_field
      logic [REG3_W-1:0] spec;
      assign spec = hw[R3_LSB[g] +: REG3_W];
      assign reg_num[g*REG5_W +: REG5_W] = REG3_MAP[spec*REG5_W +: REG5_W];
    end
  endgenerate
endmodule

/* File: src/field_extract.sv */
// fixed-position field extraction of one assembled instruction
`timescale 1ns/10ps
module field_extract
  import vlid_pkg::*;
(
  input wire logic [WORD_W-1:0] raw,
  input wire logic is32,
  input wire logic isa_mode,
  input wire logic [REG3_FIELDS*REG5_W-1:0] reg3_num,
  output fields_t fields
);
  logic [MAJ_W-1:0] major;

  assign major = is32 ? raw[MAJ32_LSB +: MAJ_W] : raw[MAJ16_LSB +: MAJ_W];

  always_comb begin
    fields = '0;
    fields.raw = raw;
    fields.is32 = is32;
    fields.major = major;
    fields.imm_right = is32 & MAJOR_IMM_RIGHT_MAP[major];
    fields.minor12_sel = is32 & MAJOR_MINOR12_MAP[major];
    // register fields sit at one place whatever the opcode
    fields.reg_a = raw[R32_A_LSB +: REG5_W];
    fields.reg_b = raw[R32_B_LSB +: REG5_W];
    fields.reg_c = raw[R32_C_LSB +: REG5_W];
    fields.reg_d = raw[R32_D_LSB +: REG5_W];
    fields.reg3_a = reg3_num[0 +: REG5_W];
    fields.reg3_b = reg3_num[REG5_W +: REG5_W];
    fields.reg3_c = reg3_num[2*REG5_W +: REG5_W];
    fields.reg5_hi = raw[R5_HI_LSB +: REG5_W];
    fields.reg5_lo = raw[R5_LO_LSB +: REG5_W];
    // immediates taken right-aligned from the low end
    fields.imm26 = raw[25:0];
    fields.imm16 = raw[15:0];
    fields.imm12 = raw[11:0];
    // other and empty fields lie between immediate and minor opcode
    fields.minor12 = raw[MINOR12_LSB +: 4];
    fields.minor6 = raw[5:0];
    fields.imm10 = raw[9:0];
    fields.imm7 = raw[6:0];
    fields.imm4 = raw[3:0];
    if (isa_mode) begin
      fields.br_off16 = {{15{raw[15]}}, raw[15:0], 1'b0};
      fields.jmp_off26 = {5'h00, raw[25:0], 1'b0};
      fields.br_off10 = {{21{raw[9]}}, raw[9:0], 1'b0};
      fields.br_off7 = {{24{raw[6]}}, raw[6:0], 1'b0};
    end else begin
      fields.br_off16 = {{14{raw[15]}}, raw[15:0], 2'b00};
      fields.jmp_off26 = {4'h0, raw[25:0], 2'b00};
    end
  end
endmodule

/* File: src/vl_decoder.sv */
// variable-length instruction decoder: halfword ordering, length, issue
//
// Behaviour
// - mix of 16-bit and 32-bit instructions
// - 6-bit major opcode at top end
// - zero to four register fields supported
// - 5-bit fields in 32-bit, 3-bit mapped
// - 5-bit register fields at fixed positions
// - immediates taken from the low end
// - offsets and jump targets are immediates
// - other fields between immediate and minor
// - empty field lies beside minor opcode
// - major opcode alone gives length, format
// - big-endian: first halfword in 31..16
// - little-endian: first halfword in 15..0
// - 32-bit built from halfwords, opcode first
// - instructions run in ascending address order
// - 5-bit field value is register number
// - variable decode only while mode is one
// - branch and jump offsets shifted by one in variable mode; in fixed mode br_off16 and jmp_off26 by two, br_off10 and br_off7 zero
// - 3-bit specifier picks one of eight
`timescale 1ns/10ps
module vl_decoder
  import vlid_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic isa_mode,
  input wire logic big_endian,
  input wire logic redirect,
  input wire logic redirect_half,
  input wire logic fetch_valid,
  input wire logic [WORD_W-1:0] fetch_word,
  output logic fetch_ready,
  output logic instr_valid,
  input wire logic instr_ready,
  output fields_t instr_fields
);
  rst_t rs_r;
  logic rst_int_b;
  dec_state_t s_r;
  dec_state_t s_nxt;
  logic [HW_W-1:0] h_first;
  logic [HW_W-1:0] h_second;
  logic [HW_W-1:0] cur_hw;
  logic [WORD_W-1:0] raw_c;
  logic is32_c;
  logic issue_c;
  logic consume_c;
  logic can_issue;
  logic [REG3_FIELDS*REG5_W-1:0] reg3_num;
  fields_t fields_c;

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rs_r <= '0;
    end else begin
      rs_r.rst_sync <= {rs_r.rst_sync[0], 1'b1};
    end
  end
  assign rst_int_b = rs_r.rst_sync[1];

  // halfword order follows endianness
  assign h_first = big_endian ? s_r.word[31:16] : s_r.word[15:0];
  assign h_second = big_endian ? s_r.word[15:0] : s_r.word[31:16];
  assign cur_hw = s_r.idx ? h_second : h_first;

  reg3_map u_reg3_map (
    .hw(raw_c[HW_W-1:0]),
    .reg_num(reg3_num)
  );

  field_extract u_field_extract (
    .raw(raw_c),
    .is32(is32_c),
    .isa_mode(isa_mode),
    .reg3_num(reg3_num),
    .fields(fields_c)
  );

  assign can_issue = !s_r.out_valid || instr_ready;

  always_comb begin
    s_nxt = s_r;
    raw_c = WORD_RESET;
    is32_c = 1'b0;
    issue_c = 1'b0;
    consume_c = 1'b0;
    if (s_r.out_valid && instr_ready) begin
      s_nxt.out_valid = 1'b0;
    end
    if (s_r.word_valid && can_issue) begin
      if (!isa_mode) begin
        raw_c = s_r.word;
        is32_c = 1'b1;
        issue_c = 1'b1;
        consume_c = 1'b1;
      end else if (s_r.hold_valid) begin
        raw_c = {s_r.hold_hw, h_first};
        is32_c = 1'b1;
        issue_c = 1'b1;
        s_nxt.hold_valid = 1'b0;
        s_nxt.idx = 1'b1;
      end else if (MAJOR_IS16_MAP[cur_hw[MAJ16_LSB +: MAJ_W]]) begin
        raw_c = {HW_RESET, cur_hw};
        issue_c = 1'b1;
        if (s_r.idx) begin
          consume_c = 1'b1;
        end else begin
          s_nxt.idx = 1'b1;
        end
      end else if (!s_r.idx) begin
        raw_c = {h_first, h_second};
        is32_c = 1'b1;
        issue_c = 1'b1;
        consume_c = 1'b1;
      end else begin
        s_nxt.hold_hw = h_second;
        s_nxt.hold_valid = 1'b1;
        consume_c = 1'b1;
      end
    end
    if (issue_c) begin
      s_nxt.out_valid = 1'b1;
      s_nxt.out = fields_c;
    end
    if (consume_c) begin
      s_nxt.word_valid = 1'b0;
      s_nxt.idx = 1'b0;
    end
    fetch_ready = !redirect && (!s_r.word_valid || consume_c);
    if (redirect) begin
      s_nxt.word_valid = 1'b0;
      s_nxt.hold_valid = 1'b0;
      s_nxt.out_valid = 1'b0;
      s_nxt.idx = 1'b0;
      s_nxt.start_half = redirect_half;
    end else if (fetch_valid && fetch_ready) begin
      s_nxt.word_valid = 1'b1;
      s_nxt.word = fetch_word;
      s_nxt.idx = s_r.start_half;
      s_nxt.start_half = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign instr_valid = s_r.out_valid;
  assign instr_fields = s_r.out;
endmodule

/* File: verif/vl_decoder_asserts.sv */
// concurrent checks on the decoder ports
`timescale 1ns/10ps
module vl_decoder_chk
  import vlid_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic isa_mode,
  input wire logic redirect,
  input wire logic fetch_ready,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire fields_t instr_fields
);
  fields_t f;
  assign f = instr_fields;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_stall;
    instr_valid && !instr_ready && !redirect;
  endsequence
  sequence s_issue;
    instr_valid && !redirect;
  endsequence
  AST_HOLD: assert property (s_stall |=> instr_valid && $stable(f)) else $error("output moved in stall");
  AST_FLUSH: assert property (redirect |-> !fetch_ready ##1 !instr_valid) else $error("redirect not flushing");
  sequence s_issue32;
    instr_valid && !redirect && f.is32;
  endsequence
  sequence s_issue16;
    instr_valid && !redirect && !f.is32;
  endsequence
  sequence s_issue_var;
    instr_valid && !redirect && isa_mode;
  endsequence
  sequence s_issue_fix;
    instr_valid && !redirect && !isa_mode;
  endsequence
  property p_maj16;
    s_issue16 |-> f.major == f.raw[15:10] && f.raw[31:16] == 16'h0000 && MAJOR_IS16_MAP[f.major];
  endproperty
  property p_reg5;
    s_issue |-> {f.reg_a, f.reg_b, f.reg_c, f.reg_d} == f.raw[25:6];
  endproperty
  property p_reg3;
    s_issue |-> f.reg3_a == REG3_MAP[f.raw[9:7]*5 +: 5] && f.reg3_b == REG3_MAP[f.raw[6:4]*5 +: 5]
      && f.reg3_c == REG3_MAP[f.raw[3:1]*5 +: 5];
  endproperty
  property p_reg16;
    s_issue |-> f.reg5_hi == f.raw[9:5] && f.reg5_lo == f.raw[4:0];
  endproperty
  property p_imm;
    s_issue |-> f.imm26 == f.raw[25:0] && f.imm16 == f.raw[15:0] && f.imm12 == f.raw[11:0]
      && f.imm10 == f.raw[9:0] && f.imm7 == f.raw[6:0] && f.imm4 == f.raw[3:0];
  endproperty
  property p_minor;
    s_issue |-> f.minor12 == f.raw[15:12] && f.minor6 == f.raw[5:0];
  endproperty
  property p_map;
    s_issue |-> f.minor12_sel == (f.is32 && f.major == 6'h08) && f.imm_right == (f.is32 && f.major != 6'h08);
  endproperty
  property p_off_var;
    s_issue_var |-> f.br_off16 == {{15{f.raw[15]}}, f.raw[15:0], 1'b0} && f.jmp_off26 == {5'h00, f.raw[25:0], 1'b0}
      && f.br_off10 == {{21{f.raw[9]}}, f.raw[9:0], 1'b0} && f.br_off7 == {{24{f.raw[6]}}, f.raw[6:0], 1'b0};
  endproperty
  property p_off_fix;
    s_issue_fix |-> f.is32 && f.br_off10 == 32'h00000000 && f.br_off7 == 32'h00000000
      && f.br_off16 == {{14{f.raw[15]}}, f.raw[15:0], 2'b00} && f.jmp_off26 == {4'h0, f.raw[25:0], 2'b00};
  endproperty
  AST_MAJ32: assert property (s_issue32 |-> f.major == f.raw[31:26]) else $error("bad major 32");
  AST_MAJ16: assert property (p_maj16) else $error("bad 16-bit form");
  AST_REG5: assert property (p_reg5) else $error("bad reg fields");
  AST_REG3: assert property (p_reg3) else $error("bad reg map");
  AST_REG16: assert property (p_reg16) else $error("bad 16-bit reg fields");
  AST_IMM: assert property (p_imm) else $error("bad immediate");
  AST_MINOR: assert property (p_minor) else $error("bad minor fields");
  AST_MAP: assert property (p_map) else $error("bad format select");
  AST_BR: assert property (p_off_var) else $error("bad branch shift");
  AST_FIX: assert property (p_off_fix) else $error("bad fixed mode");
endmodule
bind vl_decoder vl_decoder_chk u_chk (.clk(clk), .rst_b(rst_b), .isa_mode(isa_mode), .redirect(redirect),
  .fetch_ready(fetch_ready), .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_fields(instr_fields));

/* File: verif/fetch_src.sv */
// instruction fetch model feeding words in address order
`timescale 1ns/10ps
module fetch_src
  import vlid_pkg::*;
(
  input wire logic clk,
  input wire logic restart,
  input wire logic slow,
  input wire logic [3:0] len,
  input wire logic fetch_ready,
  output logic fetch_valid,
  output logic [WORD_W-1:0] fetch_word
);
  logic [WORD_W-1:0] mem [16];
  logic [3:0] ptr;
  logic gap;
  initial begin
    ptr = 4'h0;
    gap = 1'b0;
    fetch_valid = 1'b0;
    fetch_word = 32'h0;
  end
  always @(posedge clk) begin
    if (restart) begin
      ptr = 4'h0;
      fetch_valid <= #1 1'b0;
    end else if (!fetch_valid || fetch_ready) begin
      if (fetch_valid) ptr = ptr + 4'h1;
      gap = slow && !gap;
      fetch_valid <= #1 (ptr < len) && !gap;
      fetch_word <= #1 (ptr < len && !gap) ? mem[ptr] : ~fetch_word;
    end
  end
endmodule

/* File: verif/variable_length_instr_decoder_tb.sv */
// self-checking bench of the variable-length decoder
`timescale 1ns/10ps
module variable_length_instr_decoder_tb;
  import vlid_pkg::*;
  logic clk, rst_b, isa_mode, big_endian, redirect, redirect_half, instr_ready, restart, slow;
  logic fetch_valid, fetch_ready, instr_valid;
  logic [WORD_W-1:0] fetch_word;
  logic [3:0] len;
  fields_t instr_fields;
  logic [32:0] q[$];
  logic [HW_W-1:0] hw[$];
  int fail_count, total_checks, i, k;
  int seed = 32'hFFF5;
  vl_decoder u_dut (.clk(clk), .rst_b(rst_b), .isa_mode(isa_mode), .big_endian(big_endian),
    .redirect(redirect), .redirect_half(redirect_half), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
    .fetch_ready(fetch_ready), .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_fields(instr_fields));
  fetch_src u_src (.clk(clk), .restart(restart), .slow(slow), .len(len), .fetch_ready(fetch_ready),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic run(input logic m, input logic be, input logic sh, input logic sl);
    logic [WORD_W-1:0] w;
    repeat (3) @(posedge clk);
    #1;
    isa_mode = m;
    big_endian = be;
    redirect_half = sh;
    slow = sl;
    redirect = 1;
    restart = 1;
    len = 4'hC;
    hw = {};
    for (i = 0; i < 12; i++) begin
      w = $random(seed);
      u_src.mem[i] = w;
      if (!m) q.push_back({1'b1, w});
      hw.push_back(be ? w[31:16] : w[15:0]);
      hw.push_back(be ? w[15:0] : w[31:16]);
    end
    k = sh;
    while (m && k < hw.size()) begin
      if (MAJOR_IS16_MAP[hw[k][15:10]]) begin
        q.push_back({17'h0, hw[k]});
        k++;
      end else begin
        if (k + 1 < hw.size()) q.push_back({1'b1, hw[k], hw[k+1]});
        k += 2;
      end
    end
    @(posedge clk);
    #1;
    redirect = 0;
    restart = 0;
    for (i = 0; i < 400 && q.size() > 0; i++) @(posedge clk);
    if (q.size() > 0) begin
      check(33'h0, 33'h1);
      results();
    end
    repeat (4) @(posedge clk);
  endtask
  always @(posedge clk) begin
    instr_ready <= #1 1'($random(seed));
  end
  // handshake seen mid-cycle, where it is settled for the coming edge
  always @(negedge clk) begin
    if (rst_b && instr_valid && instr_ready && !redirect) begin
      if (q.size() == 0) check(33'h1, 33'h0);
      else check({instr_fields.is32, instr_fields.raw}, q.pop_front());
    end
  end
  initial begin
    isa_mode = 1;
    big_endian = 0;
    redirect = 0;
    redirect_half = 0;
    instr_ready = 0;
    restart = 0;
    slow = 0;
    len = 4'h0;
    rst_b = 0;
    repeat (6) @(posedge clk);
    check(33'({instr_valid, fetch_ready}), 33'h1);
    #1 rst_b = 1;
    for (int n = 0; n < 8; n++) run(1'b1, n[0], n[1], n[2]);
    run(1'b0, 1'b0, 1'b0, 1'b0);
    run(1'b0, 1'b1, 1'b0, 1'b1);
    run(1'b1, 1'b1, 1'b1, 1'b0);
    results();
  end
endmodule
